// file: hdl/hrpwm_map.svh
// Purpose: constants for the high-resolution pwm compare and dead-time block
// Assumes: one 16-bit counter block; included by bare name
// Notes: definitions only
`ifndef HRPWM_MAP_SVH
`define HRPWM_MAP_SVH

`define HRPWM_W 16
`define HRPWM_CNT_RST 16'h0000
`define HRPWM_CMP_RST 16'h0000
`define HRPWM_TOP_RST 16'hFFFF
`define HRPWM_BOT_RST 16'h0000
`define HRPWM_OUT_RST 1'b0
`define HRPWM_ONE 16'h0001
`define HRPWM_ONE_X 17'h00001
// setup margin software keeps before a shadow transfer
`define HRPWM_SETUP_CPU_CLKS 3
`define HRPWM_SETUP_CNT_CYCLES 40

`endif

// file: hdl/hrpwm_pkg.sv
// Purpose: types shared by the high-resolution pwm block
// Assumes: hrpwm_map.svh supplies widths
// Notes: none
`include "hrpwm_map.svh"

package hrpwm_pkg;

  typedef enum logic [1:0] {
    HRPWM_M_PLAIN  = 2'b00,
    HRPWM_M_DEAD   = 2'b01,
    HRPWM_M_PHASE  = 2'b10,
    HRPWM_M_PHDEAD = 2'b11
  } hrpwm_mode_t;

  typedef enum logic [1:0] {
    HRPWM_ACT_NOP    = 2'b00,
    HRPWM_ACT_LOW    = 2'b01,
    HRPWM_ACT_HIGH   = 2'b10,
    HRPWM_ACT_TOGGLE = 2'b11
  } hrpwm_act_t;

  typedef enum logic {
    HRPWM_DIR_UP   = 1'b0,
    HRPWM_DIR_DOWN = 1'b1
  } hrpwm_dir_t;

  typedef enum logic [3:0] {
    HRPWM_SEL_A      = 4'h0,
    HRPWM_SEL_B      = 4'h1,
    HRPWM_SEL_C      = 4'h2,
    HRPWM_SEL_D      = 4'h3,
    HRPWM_SEL_TOP    = 4'h4,
    HRPWM_SEL_BOT    = 4'h5,
    HRPWM_SEL_SH_A   = 4'h8,
    HRPWM_SEL_SH_B   = 4'h9,
    HRPWM_SEL_SH_C   = 4'hA,
    HRPWM_SEL_SH_D   = 4'hB,
    HRPWM_SEL_SH_TOP = 4'hC,
    HRPWM_SEL_SH_BOT = 4'hD
  } hrpwm_sel_t;

  typedef struct packed {
    logic [`HRPWM_W-1:0] a;
    logic [`HRPWM_W-1:0] b;
    logic [`HRPWM_W-1:0] c;
    logic [`HRPWM_W-1:0] d;
    logic [`HRPWM_W-1:0] top;
    logic [`HRPWM_W-1:0] bot;
  } hrpwm_cmp_t;

  typedef struct packed {
    hrpwm_mode_t mode;
    logic buffer_mode;
    logic updown;
    logic adt_variant;
    logic xfer_at_top;
    logic xfer_at_bottom;
    hrpwm_act_t high_level_0;
    hrpwm_act_t high_level_1;
    hrpwm_act_t low_level_0;
    hrpwm_act_t low_level_1;
  } hrpwm_cfg_t;

  typedef struct packed {
    logic wr;
    hrpwm_sel_t sel;
    logic [`HRPWM_W-1:0] data;
  } hrpwm_wr_t;

endpackage

// file: hdl/hrpwm_core.sv
// Purpose: compare, dead-time and output logic of one hi-res pwm counter block
// Assumes: count_en is a one-cycle pulse per count clock; inputs synchronous
// Notes: cpu writes arrive as a select plus data strobe on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "hrpwm_map.svh"

// Functional notes
// - up mode: count to top, reload bottom
// - up-down: up to top, down to bottom
// - restart after stop always counts up
// - mode 0 up: a,c,b,d drive L0,H0,H1,L1
// - mode 0 up-down: a/c both directions
// - each level action: nop, low, high, toggle
// - direct mode: compare writes act at once
// - buffer up: shadows load at top reload
// - buffer up-down: load at top, bottom, both
// - buffer mode still honours direct compare writes
// - modes 2,3 compute b (and d) by sum
// - b sum over top wraps by period span
// - d sum over top wraps span plus one
// - phase modes: b recomputed at match_a hit
// - mode 2: d recomputed at match_c hit
// - mode 3: only b at match_a hit
// - modes 2,3 force up count, buffer mode
// - mode 0: dead counters stay stopped
// - dead counters start on hits, stop at c/d
// - variant 0 dead-time output assignment
// - variant 1 dead-time output assignment
// - 16-bit counters; dead time from c/d
module hrpwm_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic count_en,
  input wire logic counter_run_bit,
  input wire hrpwm_pkg::hrpwm_cfg_t cfg,
  input wire hrpwm_pkg::hrpwm_wr_t cpu_wr,
  output logic high_side_output,
  output logic low_side_output,
  output logic [`HRPWM_W-1:0] main_counter,
  output logic [`HRPWM_W-1:0] dead_counter_c,
  output logic [`HRPWM_W-1:0] dead_counter_d,
  output logic count_down,
  output hrpwm_pkg::hrpwm_cmp_t match_regs,
  output hrpwm_pkg::hrpwm_cmp_t shadow_regs
);

  // state
  logic [`HRPWM_W-1:0] cnt_r;
  logic [`HRPWM_W-1:0] cnt_nxt;
  hrpwm_pkg::hrpwm_dir_t dir_r;
  hrpwm_pkg::hrpwm_dir_t dir_nxt;
  hrpwm_pkg::hrpwm_cmp_t cmp_r;
  hrpwm_pkg::hrpwm_cmp_t cmp_nxt;
  hrpwm_pkg::hrpwm_cmp_t shd_r;
  hrpwm_pkg::hrpwm_cmp_t shd_nxt;
  logic [`HRPWM_W-1:0] dcc_r;
  logic [`HRPWM_W-1:0] dcc_nxt;
  logic [`HRPWM_W-1:0] dcd_r;
  logic [`HRPWM_W-1:0] dcd_nxt;
  logic dcc_run_r;
  logic dcc_run_nxt;
  logic dcd_run_r;
  logic dcd_run_nxt;
  logic hi_r;
  logic hi_nxt;
  logic lo_r;
  logic lo_nxt;

  // decoded mode
  logic dead_mode;
  logic phase_mode;
  logic eff_updown;
  logic eff_buffer;
  logic tick;
  logic at_top;
  logic at_bot;
  logic going_up;

  // compare events
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_d;
  logic hit_a_dn;
  logic hit_c_dn;
  logic xfer;
  logic dcc_start;
  logic dcd_start;
  logic dcc_match;
  logic dcd_match;

  // phase-shift arithmetic
  logic [`HRPWM_W:0] span;
  logic [`HRPWM_W:0] top_x;
  logic [`HRPWM_W:0] sum_b;
  logic [`HRPWM_W:0] sum_d;
  logic [`HRPWM_W:0] wrap_b;
  logic [`HRPWM_W:0] wrap_d;
  logic [`HRPWM_W-1:0] next_b;
  logic [`HRPWM_W-1:0] next_d;

  function automatic logic apply_act(
    input logic cur,
    input hrpwm_pkg::hrpwm_act_t act
  );
    logic res;
    res = cur;
    case (act)
      hrpwm_pkg::HRPWM_ACT_NOP: res = cur;
      hrpwm_pkg::HRPWM_ACT_LOW: res = 1'b0;
      hrpwm_pkg::HRPWM_ACT_HIGH: res = 1'b1;
      hrpwm_pkg::HRPWM_ACT_TOGGLE: res = ~cur;
      default: res = cur;
    endcase
    return res;
  endfunction

  assign dead_mode = cfg.mode[0];
  assign phase_mode = cfg.mode[1];
  // phase modes have no direct or up-down form
  assign eff_updown = cfg.updown & ~phase_mode;
  assign eff_buffer = cfg.buffer_mode | phase_mode;
  assign tick = count_en & counter_run_bit;
  assign at_top = (cnt_r == cmp_r.top);
  assign at_bot = (cnt_r == cmp_r.bot);
  assign going_up = (dir_r == hrpwm_pkg::HRPWM_DIR_UP) | ~eff_updown;

  // hits are judged on the value the counter holds during this count cycle
  always_comb begin
    hit_a = tick & going_up & (cnt_r == cmp_r.a);
    hit_c = tick & going_up & (cnt_r == cmp_r.c);
    hit_b = tick & ~eff_updown & (cnt_r == cmp_r.b);
    hit_d = tick & ~eff_updown & (cnt_r == cmp_r.d);
    hit_a_dn = tick & ~going_up & (cnt_r == cmp_r.a);
    hit_c_dn = tick & ~going_up & (cnt_r == cmp_r.c);
  end

  // shadow transfer instant
  always_comb begin
    xfer = 1'b0;
    if (eff_buffer) begin
      if (!eff_updown) begin
        xfer = tick & at_top;
      end else begin
        xfer = tick & ((going_up & at_top & cfg.xfer_at_top) |
                       (~going_up & at_bot & cfg.xfer_at_bottom));
      end
    end
  end

  // dead counter start and stop events
  always_comb begin
    dcc_start = dead_mode & hit_a;
    dcd_start = dead_mode & (eff_updown ? hit_a_dn : hit_b);
    dcc_match = dead_mode & count_en & dcc_run_r & (dcc_r == cmp_r.c);
    dcd_match = dead_mode & count_en & dcd_run_r & (dcd_r == cmp_r.d);
  end

  // phase-shift sums, 17 bits so the overflow test sees the carry
  always_comb begin
    top_x = {1'b0, cmp_r.top};
    span = top_x - {1'b0, cmp_r.bot};
    sum_b = {1'b0, cmp_r.a} + {1'b0, shd_r.b};
    sum_d = {1'b0, cmp_r.c} + {1'b0, shd_r.d};
    wrap_b = sum_b - span;
    wrap_d = sum_d - span - `HRPWM_ONE_X;
    next_b = (sum_b > top_x) ? wrap_b[`HRPWM_W-1:0] : sum_b[`HRPWM_W-1:0];
    next_d = (sum_d > top_x) ? wrap_d[`HRPWM_W-1:0] : sum_d[`HRPWM_W-1:0];
  end

  // main counter and direction
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (!counter_run_bit) begin
      // a stopped counter always resumes upward
      dir_nxt = hrpwm_pkg::HRPWM_DIR_UP;
    end else if (count_en) begin
      if (!eff_updown) begin
        dir_nxt = hrpwm_pkg::HRPWM_DIR_UP;
        cnt_nxt = at_top ? cmp_r.bot : cnt_r + `HRPWM_ONE;
      end else begin
        case (dir_r)
          hrpwm_pkg::HRPWM_DIR_UP: begin
            if (at_top) begin
              dir_nxt = hrpwm_pkg::HRPWM_DIR_DOWN;
              cnt_nxt = cnt_r - `HRPWM_ONE;
            end else begin
              cnt_nxt = cnt_r + `HRPWM_ONE;
            end
          end
          hrpwm_pkg::HRPWM_DIR_DOWN: begin
            if (at_bot) begin
              dir_nxt = hrpwm_pkg::HRPWM_DIR_UP;
              cnt_nxt = cnt_r + `HRPWM_ONE;
            end else begin
              cnt_nxt = cnt_r - `HRPWM_ONE;
            end
          end
          default: begin
            dir_nxt = hrpwm_pkg::HRPWM_DIR_UP;
          end
        endcase
      end
    end
  end

  // compare and shadow registers
  always_comb begin
    cmp_nxt = cmp_r;
    shd_nxt = shd_r;
    if (xfer) begin
      cmp_nxt.a = shd_r.a;
      cmp_nxt.c = shd_r.c;
      cmp_nxt.top = shd_r.top;
      cmp_nxt.bot = shd_r.bot;
      if (!phase_mode) begin
        cmp_nxt.b = shd_r.b;
      end
      if (cfg.mode != hrpwm_pkg::HRPWM_M_PHASE) begin
        cmp_nxt.d = shd_r.d;
      end
    end
    // phase updates ride the compare hit, not the period boundary
    if (phase_mode && hit_a) begin
      cmp_nxt.b = next_b;
    end
    if ((cfg.mode == hrpwm_pkg::HRPWM_M_PHASE) && hit_c) begin
      cmp_nxt.d = next_d;
    end
    // cpu writes land last so a direct write is never lost to a transfer
    if (cpu_wr.wr) begin
      case (cpu_wr.sel)
        hrpwm_pkg::HRPWM_SEL_A: cmp_nxt.a = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_B: cmp_nxt.b = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_C: cmp_nxt.c = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_D: cmp_nxt.d = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_TOP: cmp_nxt.top = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_BOT: cmp_nxt.bot = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_SH_A: shd_nxt.a = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_SH_B: shd_nxt.b = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_SH_C: shd_nxt.c = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_SH_D: shd_nxt.d = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_SH_TOP: shd_nxt.top = cpu_wr.data;
        hrpwm_pkg::HRPWM_SEL_SH_BOT: shd_nxt.bot = cpu_wr.data;
        default: begin
          shd_nxt = shd_r;
        end
      endcase
    end
  end

  // dead-time counters
  always_comb begin
    dcc_nxt = dcc_r;
    dcd_nxt = dcd_r;
    dcc_run_nxt = dcc_run_r;
    dcd_run_nxt = dcd_run_r;
    if (!dead_mode) begin
      dcc_nxt = `HRPWM_CNT_RST;
      dcd_nxt = `HRPWM_CNT_RST;
      dcc_run_nxt = 1'b0;
      dcd_run_nxt = 1'b0;
    end else begin
      // a repeated start restarts from zero and stretches the dead time
      if (dcc_start) begin
        dcc_nxt = `HRPWM_CNT_RST;
        dcc_run_nxt = 1'b1;
      end else if (dcc_match) begin
        dcc_nxt = `HRPWM_CNT_RST;
        dcc_run_nxt = 1'b0;
      end else if (count_en && dcc_run_r) begin
        dcc_nxt = dcc_r + `HRPWM_ONE;
      end
      if (dcd_start) begin
        dcd_nxt = `HRPWM_CNT_RST;
        dcd_run_nxt = 1'b1;
      end else if (dcd_match) begin
        dcd_nxt = `HRPWM_CNT_RST;
        dcd_run_nxt = 1'b0;
      end else if (count_en && dcd_run_r) begin
        dcd_nxt = dcd_r + `HRPWM_ONE;
      end
    end
  end

  // output levels; level 0 action applied before level 1 on a coincidence
  always_comb begin
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    if (!dead_mode) begin
      if (hit_a) begin
        lo_nxt = apply_act(lo_nxt, cfg.low_level_0);
      end
      if (hit_d || hit_a_dn) begin
        lo_nxt = apply_act(lo_nxt, cfg.low_level_1);
      end
      if (hit_c) begin
        hi_nxt = apply_act(hi_nxt, cfg.high_level_0);
      end
      if (hit_b || hit_c_dn) begin
        hi_nxt = apply_act(hi_nxt, cfg.high_level_1);
      end
    end else if (!cfg.adt_variant) begin
      if (dcc_start) begin
        lo_nxt = apply_act(lo_nxt, cfg.low_level_0);
      end
      if (dcd_match) begin
        lo_nxt = apply_act(lo_nxt, cfg.low_level_1);
      end
      if (dcc_match) begin
        hi_nxt = apply_act(hi_nxt, cfg.high_level_0);
      end
      if (dcd_start) begin
        hi_nxt = apply_act(hi_nxt, cfg.high_level_1);
      end
    end else begin
      if (dcc_start) begin
        hi_nxt = apply_act(hi_nxt, cfg.high_level_0);
      end
      if (dcd_match) begin
        hi_nxt = apply_act(hi_nxt, cfg.high_level_1);
      end
      if (dcc_match) begin
        lo_nxt = apply_act(lo_nxt, cfg.low_level_0);
      end
      if (dcd_start) begin
        lo_nxt = apply_act(lo_nxt, cfg.low_level_1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= `HRPWM_CNT_RST;
      dir_r <= hrpwm_pkg::HRPWM_DIR_UP;
      cmp_r.a <= `HRPWM_CMP_RST;
      cmp_r.b <= `HRPWM_CMP_RST;
      cmp_r.c <= `HRPWM_CMP_RST;
      cmp_r.d <= `HRPWM_CMP_RST;
      cmp_r.top <= `HRPWM_TOP_RST;
      cmp_r.bot <= `HRPWM_BOT_RST;
      shd_r.a <= `HRPWM_CMP_RST;
      shd_r.b <= `HRPWM_CMP_RST;
      shd_r.c <= `HRPWM_CMP_RST;
      shd_r.d <= `HRPWM_CMP_RST;
      shd_r.top <= `HRPWM_TOP_RST;
      shd_r.bot <= `HRPWM_BOT_RST;
      dcc_r <= `HRPWM_CNT_RST;
      dcd_r <= `HRPWM_CNT_RST;
      dcc_run_r <= 1'b0;
      dcd_run_r <= 1'b0;
      hi_r <= `HRPWM_OUT_RST;
      lo_r <= `HRPWM_OUT_RST;
    end else begin
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      cmp_r <= cmp_nxt;
      shd_r <= shd_nxt;
      dcc_r <= dcc_nxt;
      dcd_r <= dcd_nxt;
      dcc_run_r <= dcc_run_nxt;
      dcd_run_r <= dcd_run_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
    end
  end

  assign high_side_output = hi_r;
  assign low_side_output = lo_r;
  assign main_counter = cnt_r;
  assign dead_counter_c = dcc_r;
  assign dead_counter_d = dcd_r;
  assign count_down = (dir_r == hrpwm_pkg::HRPWM_DIR_DOWN);
  assign match_regs = cmp_r;
  assign shadow_regs = shd_r;

endmodule

`default_nettype wire

// file: dv/hrpwm_core_props.sv
// Purpose: port checker for hrpwm_core
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every hrpwm_core below
`timescale 1ns/10ps
`default_nettype none
`include "hrpwm_map.svh"
module hrpwm_core_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic count_en,
  input wire logic counter_run_bit,
  input wire hrpwm_pkg::hrpwm_cfg_t cfg,
  input wire hrpwm_pkg::hrpwm_wr_t cpu_wr,
  input wire logic high_side_output,
  input wire logic low_side_output,
  input wire logic [`HRPWM_W-1:0] main_counter,
  input wire logic [`HRPWM_W-1:0] dead_counter_c,
  input wire logic [`HRPWM_W-1:0] dead_counter_d,
  input wire logic count_down,
  input wire hrpwm_pkg::hrpwm_cmp_t match_regs,
  input wire hrpwm_pkg::hrpwm_cmp_t shadow_regs
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [16:0] sum_b, sum_d;
  logic [15:0] span, nb, nd;
  // 17-bit sums so the over-top test sees the carry
  assign sum_b = {1'b0, match_regs.a} + {1'b0, shadow_regs.b};
  assign sum_d = {1'b0, match_regs.c} + {1'b0, shadow_regs.d};
  assign span = match_regs.top - match_regs.bot;
  assign nb = sum_b[15:0] - ((sum_b > {1'b0, match_regs.top}) ? span : 16'h0000);
  assign nd = sum_d[15:0] - ((sum_d > {1'b0, match_regs.top}) ? span + 16'h0001 : 16'h0000);
  sequence step_s;
    count_en && counter_run_bit;
  endsequence
  sequence top_hit_s;
    step_s ##0 (main_counter == match_regs.top && !count_down);
  endsequence
  up_wrap_a: assert property (top_hit_s ##0 (cfg.mode[1] || !cfg.updown)
    |=> main_counter == $past(match_regs.bot)) else $error("no reload at top");
  count_up_a: assert property (step_s ##0 (!count_down && main_counter != match_regs.top)
    |=> main_counter == $past(main_counter) + 16'h0001) else $error("up count slip");
  turn_up_a: assert property (step_s ##0 (count_down && main_counter == match_regs.bot)
    |=> !count_down && main_counter == $past(match_regs.bot) + 16'h0001)
    else $error("no turn at bottom");
  stop_hold_a: assert property (!counter_run_bit
    |=> !count_down && $stable(main_counter)) else $error("stop not honoured");
  wr_match_a: assert property (cpu_wr.wr && cpu_wr.sel == hrpwm_pkg::HRPWM_SEL_A
    |=> match_regs.a == $past(cpu_wr.data)) else $error("direct write lost");
  buf_load_a: assert property (top_hit_s ##0 (cfg.buffer_mode && !cfg.mode[1]
    && (!cfg.updown || cfg.xfer_at_top) && !cpu_wr.wr)
    |=> match_regs == $past(shadow_regs)) else $error("shadow transfer wrong");
  phase_b_a: assert property (step_s ##0 (cfg.mode[1] && !cpu_wr.wr
    && main_counter == match_regs.a) |=> match_regs.b == $past(nb)) else $error("b sum wrong");
  phase_d_a: assert property (step_s ##0 (cfg.mode[1] && !cfg.mode[0] && !cpu_wr.wr
    && main_counter == match_regs.c) |=> match_regs.d == $past(nd)) else $error("d sum wrong");
  dead_idle_a: assert property (!cfg.mode[0]
    |=> dead_counter_c == 16'h0000 && dead_counter_d == 16'h0000) else $error("dead count ran");
  low_set_a: assert property (step_s ##0 (cfg.mode == 2'h0 && !count_down
    && main_counter == match_regs.a && match_regs.a != match_regs.d
    && cfg.low_level_0 == hrpwm_pkg::HRPWM_ACT_HIGH) |=> low_side_output)
    else $error("low level not applied");
endmodule
bind hrpwm_core hrpwm_core_props u_props (.clock, .rst_n, .count_en, .counter_run_bit,
  .cfg, .cpu_wr, .high_side_output, .low_side_output, .main_counter, .dead_counter_c,
  .dead_counter_d, .count_down, .match_regs, .shadow_regs);
`default_nettype wire

// file: dv/hrpwm_gate_model.sv
// Purpose: high and low side switch drivers behind the outputs
// Assumes: one clock of propagation
// Notes: counts cycles with both switches on
`timescale 1ns/10ps
`default_nettype none
module hrpwm_gate_model (
  input wire logic clock,
  input wire logic high_side_output,
  input wire logic low_side_output,
  output var logic [15:0] both_on
);
  initial both_on = 16'h0000;
  always @(posedge clock) begin
    if (high_side_output && low_side_output) begin
      both_on <= both_on + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: dv/hires_pwm_compare_deadtime_test.sv
// Purpose: self-checking bench for hrpwm_core
// Assumes: counter stays within 0..15 between scenarios
// Notes: count_en gaps are random
`timescale 1ns/10ps
`default_nettype none
module hires_pwm_compare_deadtime_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic count_en = 1'b0;
  logic counter_run_bit = 1'b0;
  hrpwm_pkg::hrpwm_cfg_t cfg = '0;
  hrpwm_pkg::hrpwm_wr_t cpu_wr = '0;
  logic hi, lo, dn, lv, hv;
  logic [15:0] cnt, both_on, shb, shd;
  hrpwm_pkg::hrpwm_cmp_t mr, base, sh;
  int fails = 0;
  int n_compared = 0;
  always #4 clock = ~clock;
  always @(posedge clock) count_en <= ($urandom % 4) != 0;
  hrpwm_core dut (.clock, .rst_n, .count_en, .counter_run_bit, .cfg, .cpu_wr,
    .high_side_output(hi), .low_side_output(lo), .main_counter(cnt), .dead_counter_c(),
    .dead_counter_d(), .count_down(dn), .match_regs(mr), .shadow_regs());
  hrpwm_gate_model gates (.clock, .high_side_output(hi), .low_side_output(lo), .both_on);
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // waits for a counter value in a direction; a hang counts as a mismatch
  task automatic upto(input logic [15:0] v, input logic d);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while ((cnt !== v || dn !== d) && n < 300);
    // direction is part of the target, so a wrong turn cannot pass as a match
    if (n >= 300) chk({cnt, dn}, {v, d});
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge clock);
    cpu_wr <= '{1'b1, hrpwm_pkg::hrpwm_sel_t'(s), d};
    @(posedge clock);
    cpu_wr.wr <= 1'b0;
  endtask
  task automatic load(input logic [3:0] b, input hrpwm_pkg::hrpwm_cmp_t v);
    for (int i = 0; i < 6; i++) begin
      wr(b + 4'(i), v[95-16*i -: 16]);
    end
  endtask
  task automatic go(input logic r);
    @(posedge clock);
    counter_run_bit <= r;
  endtask
  function automatic logic act(input logic [1:0] k, input logic cur);
    case (k)
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      2'h3: return ~cur;
      default: return cur;
    endcase
  endfunction
  function automatic logic [15:0] exp_cmp(input logic [15:0] x, s, t, b, input logic e);
    logic [16:0] u;
    u = {1'b0, x} + {1'b0, s};
    return (u > {1'b0, t}) ? u[15:0] - (t - b) - {15'h0, e} : u[15:0];
  endfunction
  initial begin
    repeat (30000) @(posedge clock);
    fails++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h1C1C24D9));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    base = {16'h0002, 16'h0006, 16'h0004, 16'h0007, 16'h000F, 16'h0000};
    load(4'h0, base);
    go(1'b1);
    for (int u = 0; u < 2; u++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge clock);
        cfg <= hrpwm_pkg::hrpwm_cfg_t'({2'h0, 1'b0, u[0], 3'h0, {4{k[1:0]}}});
        upto(16'h0001, 1'b0);
        lv = lo;
        hv = hi;
        upto(16'h0003, 1'b0);
        chk(lo, act(k[1:0], lv));
        upto(16'h0005, 1'b0);
        chk(hi, act(k[1:0], hv));
        upto(u ? 16'h0003 : 16'h0007, u[0]);
        chk(hi, act(k[1:0], act(k[1:0], hv)));
        upto(u ? 16'h0001 : 16'h0008, u[0]);
        chk(lo, act(k[1:0], act(k[1:0], lv)));
      end
    end
    upto(16'h0009, 1'b1);
    go(1'b0);
    repeat (2) @(posedge clock);
    #1;
    chk(dn, 1'b0);
    @(posedge clock);
    cfg <= hrpwm_pkg::hrpwm_cfg_t'({2'h0, 1'b1, 1'b0, 3'h1, 8'h00});
    base.a = 16'h000F & 16'($urandom);
    load(4'h0, base);
    #1;
    chk(mr, base);
    sh = {$urandom, $urandom, 16'h000F, 16'h0000};
    load(4'h8, sh);
    // stopped counter still sees count clocks: keeps the shadow setup margin
    repeat (80) @(posedge clock);
    go(1'b1);
    upto(16'h000C, 1'b0);
    chk(mr, base);
    upto(16'h0001, 1'b0);
    chk(mr, sh);
    @(posedge clock);
    cfg.updown <= 1'b1;
    base = sh;
    sh = {$urandom, $urandom, 16'h000F, 16'h0000};
    load(4'h8, sh);
    upto(16'h0002, 1'b1);
    chk(mr, base);
    upto(16'h0001, 1'b0);
    chk(mr, sh);
    go(1'b0);
    @(posedge clock);
    // buffer off and up-down on: the phase modes must ignore both
    cfg <= hrpwm_pkg::hrpwm_cfg_t'({2'h2, 1'b0, 1'b1, 11'h000});
    base = {16'h000A, 16'h0000, 16'h000C, 16'h0000, 16'h000F, 16'h0002};
    load(4'h0, base);
    load(4'h8, base);
    go(1'b1);
    for (int j = 0; j < 5; j++) begin
      upto(16'h0003, 1'b0);
      if (j == 3) cfg.mode <= hrpwm_pkg::HRPWM_M_PHDEAD;
      shb = j ? 16'h000F & 16'($urandom) : 16'h0005;
      wr(4'h9, shb);
      if (j < 3) begin
        shd = j ? 16'h000F & 16'($urandom) : 16'h0003;
        wr(4'hB, shd);
      end
      upto(16'h000B, 1'b0);
      chk(mr.b, exp_cmp(16'h000A, shb, 16'h000F, 16'h0002, 1'b0));
      upto(16'h000D, 1'b0);
      if (j != 3) chk(mr.d, j < 3 ? exp_cmp(16'h000C, shd, 16'h000F, 16'h0002, 1'b1) : shd);
    end
    go(1'b0);
    @(posedge clock);
    cfg <= hrpwm_pkg::hrpwm_cfg_t'({2'h1, 5'h00, 8'h99});
    base = {16'h0003, 16'h0008, 16'h0002, 16'h0001, 16'h000F, 16'h0000};
    load(4'h0, base);
    go(1'b1);
    upto(16'h000B, 1'b0);
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      cfg.adt_variant <= v[0];
      upto(16'h0006, 1'b0);
      chk({hi, lo}, {v[0], ~v[0]});
      shb = both_on;
      upto(16'h0007, 1'b0);
      chk({hi, lo}, 2'h3);
      upto(16'h000A, 1'b0);
      chk({hi, lo}, {v[0], ~v[0]});
      chk(both_on != shb, 1'b1);
      upto(16'h000B, 1'b0);
      chk({hi, lo}, 2'h0);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
